//--- hdl/repeater_config_id_registers.sv
// Global configuration, serial configuration capture and identity registers.
// Assumes word accesses decoded from the serial management interface.
`timescale 1ns/1ns
`include "repeater_cfg.svh"

module repeater_config_id_registers
  import repeater_pkg::*;
#(
  parameter logic [3:0]  VERSION_ID = 4'h1,  // Arbitrary value.
  parameter logic [15:0] PART_ID    = 16'h1234,  // Arbitrary value.
  parameter logic [3:0]  MFR_CONT   = 4'h2,  // Arbitrary value.
  parameter logic [6:0]  MFR_CODE   = 7'h15  // Arbitrary value.
) (
  input  wire logic                   clk,
  input  wire logic                   ce,
  input  wire logic                   sys_rst,
  input  wire logic [`RPT_ADDR_W-1:0] regAddr,
  input  wire logic                   regWrEn,
  input  wire logic [31:0]            regWrData,
  input  wire logic                   regRdEn,
  output logic      [31:0]            regRdData,
  output logic                        regRdValid,
  input  wire logic [1:0]             configPins,
  input  wire logic                   configSerialClk,
  input  wire logic                   configSerialData,
  input  wire logic                   configSerialLoad,
  input  wire logic                   arbitrationPin,
  input  wire logic [1:0]             stackPositionId,
  input  wire logic                   fastBackplaneCarrierStackIn,
  input  wire logic                   slowBackplaneCollisionIn,
  input  wire logic                   slowBackplaneCarrierIn,
  input  wire logic                   outOfWindowCollision,
  input  wire logic                   frameDone,
  input  wire logic                   frameIsUnicast,
  input  wire logic                   fifoRateMismatch,
  output logic                        serialConfigMode,
  output logic      [10:0]            frameSizeLimit,
  output logic                        lateEventCount,
  output logic                        clearOnWrite,
  output logic                        statsEnable,
  output logic                        sendTermDelim,
  output logic                        fastBackplaneCarrierStack,
  output logic                        slowBackplaneCollision,
  output logic                        slowBackplaneCarrier,
  output logic                        backplaneXcvrDisable,
  output logic                        portReadableFrameCount,
  output logic                        fifoCollision,
  output logic      [`RPT_ADDR_W-1:0] zeroAddr,
  output logic                        zeroWrite,
  output logic                        statsLockout
);

  localparam int PIN_W = 11;
  reg_word_t               cfg_ff;
  logic [PIN_W-1:0]        syncA_ff;
  logic [PIN_W-1:0]        syncB_ff;
  logic                    serClkPrev_ff;
  logic                    serLoadPrev_ff;
  logic [7:0]              shift_ff;
  logic [7:0]              serialValue_ff;
  walk_state_t             walk_ff;
  logic [`RPT_ADDR_W-1:0]  walkAddr_ff;
  logic [PIN_W-1:0]        pinsRaw;
  logic [1:0]              pinsSync;
  logic                    serClkSync;
  logic                    serDataSync;
  logic                    serLoadSync;
  logic                    arbSync;
  logic [1:0]              stackSync;
  logic                    fastCsSync;
  logic                    slowColSync;
  logic                    slowCsSync;
  logic                    serClkRise;
  logic                    serLoadRise;
  logic                    cfgWrite;
  logic                    walkStart;
  reg_word_t               nxt_rdData;

  assign pinsRaw = {configPins, configSerialClk, configSerialData,
                    configSerialLoad, arbitrationPin, stackPositionId,
                    fastBackplaneCarrierStackIn, slowBackplaneCollisionIn,
                    slowBackplaneCarrierIn};

  always_ff @(posedge clk) begin
    if (ce) begin
      syncA_ff <= pinsRaw;
      syncB_ff <= syncA_ff;
    end
  end

  assign {pinsSync, serClkSync, serDataSync, serLoadSync, arbSync,
          stackSync, fastCsSync, slowColSync, slowCsSync} = syncB_ff;

  assign serClkRise  = serClkSync & ~serClkPrev_ff;
  assign serLoadRise = serLoadSync & ~serLoadPrev_ff;
  assign cfgWrite    = regWrEn & (regAddr == `RPT_OFS_CONFIG);
  assign walkStart   = cfgWrite & regWrData[`RPT_BIT_ZERO];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_ff <= `RPT_CONFIG_RST;
    end else if (ce && cfgWrite) begin
      cfg_ff <= regWrData & `RPT_CONFIG_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serClkPrev_ff  <= serClkSync;
      serLoadPrev_ff <= serLoadSync;
      shift_ff       <= 8'h00;
    end else if (ce) begin
      serClkPrev_ff  <= serClkSync;
      serLoadPrev_ff <= serLoadSync;
      if (serClkRise) begin
        shift_ff <= {shift_ff[6:0], serDataSync};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serialValue_ff <= {6'h00, pinsSync};
    end else if (ce) begin
      if (!cfg_ff[`RPT_BIT_CFGMODE]) begin
        serialValue_ff <= {6'h00, pinsSync};
      end else if (serLoadRise) begin
        serialValue_ff <= shift_ff;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      walk_ff     <= WALK_IDLE;
      walkAddr_ff <= 9'h000;
    end else if (ce) begin
      case (walk_ff)
        WALK_IDLE: begin
          walkAddr_ff <= 9'h000;
          if (walkStart) begin
            walk_ff <= WALK_RUN;
          end
        end
        WALK_RUN: begin
          if (walkAddr_ff == `RPT_ZERO_LAST) begin
            walk_ff     <= WALK_IDLE;
            walkAddr_ff <= 9'h000;
          end else begin
            walkAddr_ff <= walkAddr_ff + 9'h001;
          end
        end
        default: begin
          walk_ff <= WALK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      zeroAddr     <= 9'h000;
      zeroWrite    <= 1'b0;
      statsLockout <= 1'b0;
    end else if (ce) begin
      zeroAddr     <= walkAddr_ff;
      zeroWrite    <= (walk_ff == WALK_RUN);
      statsLockout <= (walk_ff == WALK_RUN);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serialConfigMode <= 1'b0;
      frameSizeLimit   <= `RPT_FRAME_NORMAL;
      clearOnWrite     <= 1'b0;
      statsEnable      <= 1'b1;
      sendTermDelim    <= 1'b0;
    end else if (ce) begin
      serialConfigMode <= cfg_ff[`RPT_BIT_CFGMODE];
      frameSizeLimit   <= cfg_ff[`RPT_BIT_EXTFRAME] ?
                          `RPT_FRAME_EXTENDED : `RPT_FRAME_NORMAL;
      clearOnWrite     <= cfg_ff[`RPT_BIT_CLRWRITE];
      statsEnable      <= cfg_ff[`RPT_BIT_STATSEN];
      sendTermDelim    <= cfg_ff[`RPT_BIT_SENDTR];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fastBackplaneCarrierStack <= 1'b0;
      slowBackplaneCollision    <= 1'b0;
      slowBackplaneCarrier      <= 1'b0;
      backplaneXcvrDisable      <= 1'b0;
    end else if (ce) begin
      fastBackplaneCarrierStack <= fastCsSync &
        ~(cfg_ff[`RPT_BIT_ISO_FAST] | cfg_ff[`RPT_BIT_ISO_SLOW]);
      slowBackplaneCollision    <= slowColSync &
        ~cfg_ff[`RPT_BIT_ISO_SLOW];
      slowBackplaneCarrier      <= slowCsSync &
        ~cfg_ff[`RPT_BIT_ISO_SLOW];
      backplaneXcvrDisable      <= cfg_ff[`RPT_BIT_ISO_FAST] |
        cfg_ff[`RPT_BIT_ISO_SLOW];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lateEventCount         <= 1'b0;
      portReadableFrameCount <= 1'b0;
      fifoCollision          <= 1'b0;
    end else if (ce) begin
      lateEventCount         <= outOfWindowCollision &
        cfg_ff[`RPT_BIT_LATEEVT];
      portReadableFrameCount <= frameDone &
        (frameIsUnicast | ~cfg_ff[`RPT_BIT_UNICAST]);
      fifoCollision          <= fifoRateMismatch &
        cfg_ff[`RPT_BIT_FIFOERR];
    end
  end

  always_comb begin
    nxt_rdData = 32'h0000_0000;
    case (regAddr)
      `RPT_OFS_CONFIG: begin
        nxt_rdData = cfg_ff;
        nxt_rdData[`RPT_BIT_ARBIT] = arbSync;
        nxt_rdData[`RPT_BIT_ZERO]  = (walk_ff == WALK_RUN);
      end
      `RPT_OFS_SERCFG: begin
        nxt_rdData = {24'h00_0000, serialValue_ff};
      end
      `RPT_OFS_IDENT: begin
        nxt_rdData = {VERSION_ID, PART_ID, MFR_CONT, MFR_CODE,
                      (stackSync == 2'h0)};
      end
      default: nxt_rdData = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdData  <= 32'h0000_0000;
      regRdValid <= 1'b0;
    end else if (ce) begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        regRdData <= nxt_rdData;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_reset_vals;
    $past(sys_rst) |-> !serialConfigMode && statsEnable && !sendTermDelim
      && (cfg_ff == `RPT_CONFIG_RST);
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("Bad reset value.");
  property p_frame_limit;
    ce |=> frameSizeLimit == ($past(cfg_ff[`RPT_BIT_EXTFRAME]) ?
      `RPT_FRAME_EXTENDED : `RPT_FRAME_NORMAL);
  endproperty
  a_frame_limit: assert property (p_frame_limit)
    else $error("Bad frame limit.");
  property p_late_gate;
    ce && !cfg_ff[`RPT_BIT_LATEEVT] |=> !lateEventCount;
  endproperty
  a_late_gate: assert property (p_late_gate)
    else $error("Late event leaked.");
  property p_unicast;
    ce && frameDone && cfg_ff[`RPT_BIT_UNICAST] && !frameIsUnicast
      |=> !portReadableFrameCount;
  endproperty
  a_unicast: assert property (p_unicast)
    else $error("Multicast counted.");
  property p_xcvr;
    ce |=> backplaneXcvrDisable ==
      $past(cfg_ff[`RPT_BIT_ISO_FAST] | cfg_ff[`RPT_BIT_ISO_SLOW]);
  endproperty
  a_xcvr: assert property (p_xcvr)
    else $error("Bad disable output.");
  property p_slow_iso;
    ce && cfg_ff[`RPT_BIT_ISO_SLOW] |=> !slowBackplaneCollision
      && !slowBackplaneCarrier && !fastBackplaneCarrierStack;
  endproperty
  a_slow_iso: assert property (p_slow_iso)
    else $error("Slow isolate leak.");
  property p_walk_end;
    $fell(statsLockout) |-> $past(zeroAddr) == `RPT_ZERO_LAST;
  endproperty
  a_walk_end: assert property (p_walk_end)
    else $error("Walk ended early.");
  property p_walk_start;
    ce && walk_ff == WALK_IDLE && walkStart |=> ce [*2] |-> statsLockout
      && zeroWrite && zeroAddr == 9'h000;
  endproperty
  a_walk_start: assert property (p_walk_start)
    else $error("Walk start bad.");
  property p_ro_write;
    ce && regWrEn && regAddr == `RPT_OFS_SERCFG && cfg_ff[`RPT_BIT_CFGMODE]
      && !serLoadRise |=> $stable(serialValue_ff);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("RO value changed.");
  property p_first_chain;
    ce && regRdEn && regAddr == `RPT_OFS_IDENT
      |=> regRdData[0] == ($past(stackSync) == 2'h0);
  endproperty
  a_first_chain: assert property (p_first_chain)
    else $error("Bad chain bit.");

  c_walk: cover property (walk_ff == WALK_RUN ##1 walk_ff == WALK_IDLE);
  c_serial: cover property (ce && serLoadRise && cfg_ff[`RPT_BIT_CFGMODE]);
  c_id_read: cover property (ce && regRdEn && regAddr == `RPT_OFS_IDENT);
  c_iso: cover property (ce && cfg_ff[`RPT_BIT_ISO_FAST] && fastCsSync);

endmodule // repeater_config_id_registers

//--- hdl/repeater_cfg.svh
// Constants for the repeater configuration and identification registers.
// Assumes a 25 MHz system clock and word-wide management register accesses.
`ifndef REPEATER_CFG_SVH
`define REPEATER_CFG_SVH

`define RPT_ADDR_W          9
`define RPT_OFS_CONFIG      9'h13A
`define RPT_OFS_SERCFG      9'h13B
`define RPT_OFS_IDENT       9'h13C

`define RPT_BIT_CFGMODE     14
`define RPT_BIT_EXTFRAME    13
`define RPT_BIT_LATEEVT     12
`define RPT_BIT_CLRWRITE    11
`define RPT_BIT_STATSEN     10
`define RPT_BIT_SENDTR      9
`define RPT_BIT_ISO_FAST    8
`define RPT_BIT_ISO_SLOW    7
`define RPT_BIT_UNICAST     6
`define RPT_BIT_ARBIT       5
`define RPT_BIT_ZERO        4
`define RPT_BIT_FIFOERR     3

`define RPT_CONFIG_RST      32'h0000_0408
`define RPT_CONFIG_WMASK    32'h0000_7FC8
`define RPT_SERCFG_RST      8'h00

`define RPT_FRAME_NORMAL    11'h5EE
`define RPT_FRAME_EXTENDED  11'h5F2

`define RPT_CLK_PERIOD_NS   40
`define RPT_ZERO_TIME_US    15
`define RPT_ZERO_CYCLES     ((`RPT_ZERO_TIME_US * 1000) / `RPT_CLK_PERIOD_NS)
`define RPT_ZERO_LAST       9'(`RPT_ZERO_CYCLES - 1)

`endif

//--- hdl/repeater_pkg.sv
// Types shared by the repeater configuration register bank.
// Assumes the constants header is included by each user.
package repeater_pkg;
  typedef enum logic {WALK_IDLE, WALK_RUN} walk_state_t;
  typedef logic [31:0] reg_word_t;
endpackage

//--- verification/mgmt_proc_model.sv
// Management processor model driving the word-wide register port.
// Assumes one clock; requests launch just after a rising edge.
`timescale 1ns/1ns
`include "repeater_cfg.svh"

module mgmt_proc_model (
  input  wire logic                   clk,
  output logic      [`RPT_ADDR_W-1:0] regAddr,
  output logic                        regWrEn,
  output logic      [31:0]            regWrData,
  output logic                        regRdEn,
  input  wire logic [31:0]            regRdData,
  input  wire logic                   regRdValid
);
  initial begin
    regAddr   = '0;
    regWrEn   = 1'b0;
    regWrData = '0;
    regRdEn   = 1'b0;
  end

  // Writes one word; configuration writes go out with bit 2 and bits 31:15 cleared.
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrEn   <= 1'b1;
    regWrData <= (a == `RPT_OFS_CONFIG) ? (d & 32'h0000_7FFB) : d;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask

  // Reads one word and reports whether the answer came on time.
  task automatic rd(input logic [8:0] a, output logic [31:0] q,
                    output logic ok);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1;
    ok = regRdValid;
    q  = regRdData;
  endtask
endmodule // mgmt_proc_model

//--- verification/repeater_config_id_registers_test.sv
// Self-checking bench for the configuration and identity registers.
// Assumes the management processor model for all register traffic.
`timescale 1ns/1ns
`include "repeater_cfg.svh"

`define CHK(a, e) \
  begin \
    cmpCount++; \
    if ((a) !== (e)) begin \
      miscompares++; \
      $display("Error at %0t got %h expected %h", $time, (a), (e)); \
    end \
  end

module repeater_config_id_registers_test;
  import repeater_pkg::*;
  logic                   clk = 1'b0;
  logic                   sysRst = 1'b1;
  logic                   ceOn = 1'b1;
  logic [`RPT_ADDR_W-1:0] regAddr;
  logic                   regWrEn, regRdEn, regRdValid;
  logic [31:0]            regWrData, regRdData, rdQ;
  logic                   rdOk;
  logic [1:0]             pins = 2'h0, stackId = 2'h0;
  logic                   sClk = 0, sData = 0, sLoad = 0, arb = 0;
  logic                   fastIn = 1, slowColIn = 1, slowCarIn = 1;
  logic                   ooc = 0, fDone = 0, uniq = 0, fifoMm = 0;
  logic                   cfgMode, clrWr, stEn, sendTr, fastOut;
  logic                   slowCol, slowCar, xcvrOff, lateEv, rfCnt;
  logic                   fifoCol, zeroWr, lockout;
  logic [10:0]            frameLim;
  logic [8:0]             zAddr, lastAddr = '0;
  int                     miscompares = 0, cmpCount = 0, lockCnt = 0;
  // Identity fields are arbitrary values.
  localparam logic [31:0] IDW = {4'h3, 16'hC0DE, 4'h6, 7'h2A, 1'b0};
  localparam logic [31:0] ISOW [3] = '{32'h408, 32'h508, 32'h488};
  localparam logic [3:0]  ISOE [3] = '{4'hE, 4'h7, 4'h1};

  mgmt_proc_model mp (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid));

  repeater_config_id_registers #(.VERSION_ID(4'h3), .PART_ID(16'hC0DE),
    .MFR_CONT(4'h6), .MFR_CODE(7'h2A)) dut (
    .clk(clk), .ce(ceOn), .sys_rst(sysRst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .regRdValid(regRdValid), .configPins(pins),
    .configSerialClk(sClk), .configSerialData(sData),
    .configSerialLoad(sLoad), .arbitrationPin(arb),
    .stackPositionId(stackId), .fastBackplaneCarrierStackIn(fastIn),
    .slowBackplaneCollisionIn(slowColIn),
    .slowBackplaneCarrierIn(slowCarIn), .outOfWindowCollision(ooc),
    .frameDone(fDone), .frameIsUnicast(uniq), .fifoRateMismatch(fifoMm),
    .serialConfigMode(cfgMode), .frameSizeLimit(frameLim),
    .lateEventCount(lateEv), .clearOnWrite(clrWr), .statsEnable(stEn),
    .sendTermDelim(sendTr), .fastBackplaneCarrierStack(fastOut),
    .slowBackplaneCollision(slowCol), .slowBackplaneCarrier(slowCar),
    .backplaneXcvrDisable(xcvrOff), .portReadableFrameCount(rfCnt),
    .fifoCollision(fifoCol), .zeroAddr(zAddr), .zeroWrite(zeroWr),
    .statsLockout(lockout));

  initial begin
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (lockout === 1'b1) lockCnt++;
    if (zeroWr === 1'b1) lastAddr = zAddr;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic rdChk(input logic [8:0] a, input logic [31:0] e);
    mp.rd(a, rdQ, rdOk);
    `CHK(rdOk, 1'b1)
    `CHK(rdQ, e)
  endtask

  task automatic pulse(input logic u, input logic [2:0] e);
    ooc    <= 1'b1;
    fDone  <= 1'b1;
    fifoMm <= 1'b1;
    uniq   <= u;
    cyc(1);
    ooc    <= 1'b0;
    fDone  <= 1'b0;
    fifoMm <= 1'b0;
    #1;
    `CHK({lateEv, rfCnt, fifoCol}, e)
    cyc(1);
  endtask

  task automatic shiftByte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sData <= b[i];
      cyc(4);
      sClk <= 1'b1;
      cyc(4);
      sClk <= 1'b0;
    end
    sLoad <= 1'b1;
    cyc(4);
    sLoad <= 1'b0;
    cyc(8);
  endtask

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    cyc(20000);
    miscompares++;
    close_out();
  end

  initial begin
    cyc(16);
    sysRst <= 1'b0;
    #1;
    `CHK({stEn, frameLim}, {1'b1, 11'h5EE})
    rdChk(9'h13A, 32'h408);
    mp.wr(9'h13A, 32'hFFFF_6E0C);
    cyc(3);
    `CHK({cfgMode, clrWr, stEn, sendTr}, 4'hF)
    `CHK(frameLim, 11'h5F2)
    rdChk(9'h13A, 32'h6E08);
    for (int i = 0; i < 3; i++) begin
      mp.wr(9'h13A, ISOW[i]);
      cyc(4);
      `CHK({fastOut, slowCol, slowCar, xcvrOff}, ISOE[i])
    end
    mp.wr(9'h13A, 32'h400);
    cyc(3);
    pulse(1'b0, 3'b010);
    mp.wr(9'h13A, 32'h1448);
    cyc(3);
    pulse(1'b0, 3'b101);
    pulse(1'b1, 3'b111);
    arb <= 1'b1;
    cyc(4);
    mp.wr(9'h13A, 32'h1448);
    rdChk(9'h13A, 32'h1468);
    pins <= 2'h2;
    mp.wr(9'h13A, 32'h408);
    cyc(4);
    rdChk(9'h13B, 32'h2);
    mp.wr(9'h13A, 32'h4408);
    cyc(3);
    shiftByte(8'hA5);
    rdChk(9'h13B, 32'hA5);
    mp.wr(9'h13B, 32'hFFFF_FFFF);
    mp.wr(9'h13C, 32'h0);
    rdChk(9'h13B, 32'hA5);
    rdChk(9'h13C, IDW | 32'h1);
    stackId <= 2'h1;
    cyc(4);
    rdChk(9'h13C, IDW);
    rdChk(9'h13D, 32'h0);
    mp.wr(9'h13A, 32'h418);
    rdChk(9'h13A, 32'h438);
    cyc(400);
    `CHK(lockCnt, `RPT_ZERO_CYCLES)
    `CHK(lastAddr, 9'h176)
    rdChk(9'h13A, 32'h428);
    cyc(1);
    ceOn <= 1'b0;
    mp.wr(9'h13A, 32'h0);
    ceOn <= 1'b1;
    rdChk(9'h13A, 32'h428);
    mp.wr(9'h13A, 32'h6E08);
    sysRst <= 1'b1;
    cyc(3);
    sysRst <= 1'b0;
    #1;
    `CHK({stEn, frameLim}, {1'b1, 11'h5EE})
    rdChk(9'h13A, 32'h428);
    close_out();
  end
endmodule // repeater_config_id_registers_test
